// ==== logic/sdtc_pkg.sv ====
// Purpose: Shared constants and types for the SDRAM command-level device core.
// Assumes: One 40 MHz system clock; pins sampled on its rising edge.
// Notes:   Timing minima bind the controller; they are kept here for the bench.

// ============================================================
// Package
package sdtc_pkg;
    // Clock and widths
    localparam int CLK_PERIOD_PS = 25000;
    localparam int DQ_W = 32;
    localparam int DQM_W = 4;
    localparam int BYTE_W = 8;
    localparam int BA_W = 2;
    localparam int ADDR_W = 13;
    localparam int COL_W = 9;
    localparam int MEM_COL_W = 4;
    localparam int MEM_IDX_W = BA_W + MEM_COL_W;
    localparam int MEM_WORDS = 1 << MEM_IDX_W;

    // Mode register field positions
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_WBL_BIT = 9;

    // Mode register codes and reset value (latency 2, burst 1)
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [2:0] CL_MIN = 3'h2;
    localparam logic [ADDR_W-1:0] MODE_RST = 13'h0020;

    // Command codes on {row strobe, column strobe, write strobe}
    localparam logic [2:0] CMD_MRS = 3'h0;
    localparam logic [2:0] CMD_AREF = 3'h1;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_NOP = 3'h7;

    // Controller-side minima, fast grade, in ps (power-up in us), and cycles rounded up
    localparam int T_RC_PS = 66000;
    localparam int T_RRD_PS = 12000;
    localparam int T_RCD_PS = 18000;
    localparam int T_RP_PS = 18000;
    localparam int T_RAS_PS = 42000;
    localparam int T_SRX_PS = 70000;
    localparam int T_PWRUP_US = 200;
    localparam int T_RC_CYC = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RRD_CYC = (T_RRD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RCD_CYC = (T_RCD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_RAS_CYC = (T_RAS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_SRX_CYC = (T_SRX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int T_MRS_CYC = 2;
    localparam int T_CCD_CYC = 1;
    localparam int PWRUP_CYC = (T_PWRUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Device operating state
    typedef enum logic {ST_RUN = 1'b0, ST_SREF = 1'b1} sdtc_state_t;

    // Controller-driven pins sampled each edge
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic cke;
        logic [BA_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [DQM_W-1:0] dqm;
    } sdtc_pins_t;
endpackage : sdtc_pkg

// ==== logic/sdtc_buf2.sv ====
// Purpose: Two-entry valid/ready buffer in the read data path.
// Assumes: Single clock, active-low synchronous-released reset.
// Notes:   Full stays honest: in_ready drops with both entries held.

`timescale 1ns/1ps

// ============================================================
// Two-entry buffer
module sdtc_buf2 #(
    parameter int W = 32
) (
    input wire logic clk,              // System clock
    input wire logic rst_n,            // Synchronised reset
    input wire logic in_valid,         // Word offered
    output logic in_ready,             // Room for a word
    input wire logic [W-1:0] in_data,  // Offered word
    output logic out_valid,            // Word available
    input wire logic out_ready,        // Drain side takes word
    output logic [W-1:0] out_data      // Oldest word
);
    logic [W-1:0] ent_q [2];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    // Handshake terms
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = ent_q[rp_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) wp_q <= ~wp_q;
            if (pop) rp_q <= ~rp_q;
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage; no reset needed, guarded by count
    always_ff @(posedge clk) begin
        if (push) ent_q[wp_q] <= in_data;
    end
endmodule : sdtc_buf2

// ==== logic/sdtc_core.sv ====
// Purpose: Command-level SDRAM device core: mode, bursts, masks, suspend, self refresh.
// Assumes: Controller keeps its own timing minima; array is a small stand-in.
// Notes:   Summary of operation follows.

`timescale 1ns/1ps

// ============================================================
// Device core
module sdtc_core
    import sdtc_pkg::*;
(
    input wire logic clk_sys,                 // 40 MHz system clock
    input wire logic rstn,                    // Asynchronous reset, active low
    input wire sdtc_pins_t pins,              // Command, address, gate, mask pins
    input wire logic [DQ_W-1:0] dq_in,        // Data pin input side
    output logic [DQ_W-1:0] dq_out,           // Data pin output side
    output logic [DQM_W-1:0] dq_oe_n,         // Per-byte output enable, low drives
    output logic sref_active                  // High while in self refresh
);
    // ============================================================
    // Reset release
    logic rst_s1_q;
    logic rst_n_q;

    // Two-stage release keeps recovery off the async path
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ============================================================
    // Clock gate and command decode
    sdtc_state_t state_q;
    logic ck_en_q;
    logic [ADDR_W-1:0] mode_q;
    logic [2:0] cmd;
    logic cmd_live;
    logic rd_go;
    logic wr_go;
    logic stop_go;
    logic col_cmd;
    logic sref_go;

    assign cmd = {pins.ras_n, pins.cas_n, pins.we_n};
    // Commands count only with the internal clock running
    assign cmd_live = ck_en_q & ~pins.cs_n & (state_q == ST_RUN);
    assign rd_go = cmd_live & (cmd == CMD_RD);
    assign wr_go = cmd_live & (cmd == CMD_WR);
    assign stop_go = cmd_live & ((cmd == CMD_BST) | (cmd == CMD_PRE));
    assign col_cmd = rd_go | wr_go | stop_go;
    assign sref_go = cmd_live & (cmd == CMD_AREF) & ~pins.cke;

    // Internal clock follows the gate one edge late
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) ck_en_q <= 1'b1;
        else ck_en_q <= pins.cke;
    end

    // Self refresh: only the gate is watched while inside
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) state_q <= ST_RUN;
        else begin
            unique case (state_q)
                ST_RUN: if (sref_go) state_q <= ST_SREF;
                ST_SREF: if (pins.cke) state_q <= ST_RUN;
            endcase
        end
    end
    assign sref_active = (state_q == ST_SREF);

    // Mode register programming
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) mode_q <= MODE_RST;
        else if (cmd_live && cmd == CMD_MRS) mode_q <= pins.addr;
    end

    // ============================================================
    // Burst sequencing
    logic [2:0] bl_code;
    logic [2:0] cl_code;
    logic [COL_W-1:0] bl_mask;
    logic rd_act_q;
    logic wr_act_q;
    logic [COL_W-1:0] col_start_q;
    logic [BA_W-1:0] bank_q;
    logic [COL_W-1:0] cnt_q;
    logic [COL_W-1:0] col_cur;
    logic last_beat;
    logic wr_beat;
    logic rd_push;
    logic buf_in_rdy;
    logic one_beat;

    assign bl_code = mode_q[MR_BL_LSB +: 3];
    assign cl_code = mode_q[MR_CL_LSB +: 3];

    // Burst span mask; full page wraps over the whole row
    always_comb begin
        unique case (bl_code)
            BL_1: bl_mask = 9'h000;
            BL_2: bl_mask = 9'h001;
            BL_4: bl_mask = 9'h003;
            BL_8: bl_mask = 9'h007;
            default: bl_mask = 9'h1ff;
        endcase
    end

    // Interleave flips bits, sequential wraps inside the span
    assign col_cur = mode_q[MR_BT_BIT] ? (col_start_q ^ cnt_q) :
        ((col_start_q & ~bl_mask) | ((col_start_q + cnt_q) & bl_mask));
    // Full page never ends on its own, only by a new command
    assign last_beat = (bl_code != BL_FULL) && (cnt_q == bl_mask);
    assign one_beat = (bl_code == BL_1) | mode_q[MR_WBL_BIT];
    assign wr_beat = wr_act_q & ck_en_q & ~col_cmd;
    // Fetch runs one edge after the command; a following column command still lets it land
    assign rd_push = rd_act_q & ck_en_q & buf_in_rdy;

    // Burst engine; a new column command cuts the old burst
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            col_start_q <= '0;
            bank_q <= '0;
            cnt_q <= '0;
        end else if (rd_go) begin
            rd_act_q <= 1'b1;
            wr_act_q <= 1'b0;
            col_start_q <= pins.addr[COL_W-1:0];
            bank_q <= pins.ba;
            cnt_q <= '0;
        end else if (wr_go) begin
            rd_act_q <= 1'b0;
            wr_act_q <= ~one_beat;
            col_start_q <= pins.addr[COL_W-1:0];
            bank_q <= pins.ba;
            cnt_q <= 9'h001;
        end else if (stop_go || sref_go) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
        end else if (ck_en_q) begin
            // Frozen while the internal clock is held
            if (rd_push || wr_beat) begin
                cnt_q <= cnt_q + 9'h001;
                if (last_beat) begin
                    rd_act_q <= 1'b0;
                    wr_act_q <= 1'b0;
                end
            end
        end
    end

    // ============================================================
    // Storage array
    logic [DQ_W-1:0] mem_q [MEM_WORDS];
    logic [MEM_IDX_W-1:0] wr_idx;
    logic [MEM_IDX_W-1:0] rd_idx;
    logic wr_en;

    assign wr_en = wr_go | wr_beat;
    assign wr_idx = wr_go ? {pins.ba, pins.addr[MEM_COL_W-1:0]} :
        {bank_q, col_cur[MEM_COL_W-1:0]};
    assign rd_idx = {bank_q, col_cur[MEM_COL_W-1:0]};

    // Per-byte write, each lane gated by its mask bit
    // One process owns the array, so each lane loop stays inside it
    always_ff @(posedge clk_sys) begin
        for (int b = 0; b < DQM_W; b++) begin
            if (wr_en && !pins.dqm[b]) begin
                mem_q[wr_idx][b*BYTE_W +: BYTE_W] <= dq_in[b*BYTE_W +: BYTE_W];
            end
        end
    end

    // ============================================================
    // Read data path
    logic buf_out_vld;
    logic [DQ_W-1:0] buf_out_data;
    logic pop;
    logic stg_vld_q;
    logic [DQ_W-1:0] stg_data_q;
    logic out_vld;
    logic [DQ_W-1:0] out_word;

    // Buffer lets a suspended drain stall the burst without dropping words
    sdtc_buf2 #(.W(DQ_W)) u_rdbuf (
        .clk(clk_sys),
        .rst_n(rst_n_q),
        .in_valid(rd_push),
        .in_ready(buf_in_rdy),
        .in_data(mem_q[rd_idx]),
        .out_valid(buf_out_vld),
        .out_ready(ck_en_q),
        .out_data(buf_out_data)
    );

    // Latency three adds one stage behind the buffer, frozen with the gate
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stg_vld_q <= 1'b0;
            stg_data_q <= '0;
        end else if (ck_en_q) begin
            stg_vld_q <= buf_out_vld;
            stg_data_q <= buf_out_data;
        end
    end
    assign out_vld = (cl_code == CL_MIN) ? buf_out_vld : stg_vld_q;
    assign out_word = (cl_code == CL_MIN) ? buf_out_data : stg_data_q;
    assign pop = out_vld & ck_en_q;

    // Output stage; held while suspended, released in self refresh
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dq_out <= '0;
            dq_oe_n <= '1;
        end else if (state_q == ST_SREF) begin
            dq_oe_n <= '1;
        end else if (pop) begin
            dq_out <= out_word;
            dq_oe_n <= pins.dqm;
        end else if (ck_en_q) begin
            dq_oe_n <= '1;
        end
    end

    // ============================================================
    // Checks
    logic [MEM_IDX_W-1:0] chk_idx_q;
    logic [DQ_W-1:0] chk_old_q;

    // Snapshot of the word about to be written
    always_ff @(posedge clk_sys) begin
        chk_idx_q <= wr_idx;
        chk_old_q <= mem_q[wr_idx];
    end

    a_mask_blocks: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        wr_en && (&pins.dqm) |=> mem_q[chk_idx_q] == chk_old_q)
        else $error("masked write changed storage");
    a_read_lane_off: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        pop && pins.dqm[0] && state_q == ST_RUN |=> dq_oe_n[0])
        else $error("masked read lane still driven");
    a_read_lane_on: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        pop && !pins.dqm[1] && state_q == ST_RUN |=> !dq_oe_n[1] && dq_out == $past(out_word))
        else $error("unmasked read lane not driven");
    a_col_back2back: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        rd_go ##1 wr_go |=> !rd_act_q && col_start_q == $past(pins.addr[COL_W-1:0]))
        else $error("back to back column command lost");
    a_sref_holds: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        state_q == ST_SREF && !pins.cke |=> state_q == ST_SREF && (&dq_oe_n) && $stable(mode_q))
        else $error("self refresh left or disturbed");
    a_sref_entry: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        sref_go |=> state_q == ST_SREF ##1 (&dq_oe_n))
        else $error("self refresh not entered");
    a_aref_stays: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        cmd_live && cmd == CMD_AREF && pins.cke |=> state_q == ST_RUN)
        else $error("auto refresh entered self refresh");
    a_suspend_freeze: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        !pins.cke && state_q == ST_RUN |-> ##2 $stable(dq_out) && $stable(cnt_q))
        else $error("burst moved while suspended");
    a_resume_lat: assert property (@(posedge clk_sys) disable iff (!rst_n_q)
        !ck_en_q && pins.cke |=> ck_en_q)
        else $error("resume latency wrong");

    c_read_burst: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
        rd_go ##[1:12] (pop && !pins.dqm[0]));
    c_write_burst: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
        wr_go ##1 wr_beat ##1 wr_beat);
    c_sref_cycle: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
        sref_go ##[2:20] (state_q == ST_SREF && pins.cke));
    c_suspend_read: cover property (@(posedge clk_sys) disable iff (!rst_n_q)
        rd_act_q && !pins.cke ##1 !ck_en_q && !buf_in_rdy);
endmodule : sdtc_core

// ==== verification/sdtc_ctrl_model.sv ====
// Purpose: Controller-side model driving the command, mask and data pins of the core.
// Assumes: Fast-grade minima from the package, already rounded up to 25 ns cycles.
// Notes:   Each task waits an edge before it drives, so calls chain back to back.

`timescale 1ns/1ps

// ============================================================
// Controller model
module sdtc_ctrl_model
    import sdtc_pkg::*;
(
    input wire logic clk_sys,       // System clock
    output sdtc_pins_t pins,        // Command pins
    output logic [DQ_W-1:0] wdata,  // Write data lanes
    output logic wdrive             // High while data is driven
);
    // Power-on state: no-op, gate and mask high
    initial begin
        pins = {1'b0, CMD_NOP, 1'b1, 2'h0, 13'h0000, 4'hf};
        wdata = 32'h00000000;
        wdrive = 1'b0;
    end

    // One command edge
    task automatic cmd(input logic [2:0] c, input logic [BA_W-1:0] b,
                       input logic [ADDR_W-1:0] a, input logic ck, input logic [DQM_W-1:0] m);
        @(posedge clk_sys);
        pins <= {1'b0, c, ck, b, a, m};
    endtask : cmd

    task automatic nop(input int n);
        repeat (n) cmd(CMD_NOP, 2'h0, 13'h0000, 1'b1, 4'h0);
    endtask : nop

    // Pause, precharge all, mode set, two refreshes
    task automatic init(input logic [ADDR_W-1:0] mode);
        repeat (PWRUP_CYC) @(posedge clk_sys);
        cmd(CMD_PRE, 2'h0, 13'h0400, 1'b1, 4'hf);
        nop(T_RP_CYC);
        cmd(CMD_MRS, 2'h0, mode, 1'b1, 4'hf);
        nop(T_MRS_CYC);
        repeat (2) begin
            cmd(CMD_AREF, 2'h0, 13'h0000, 1'b1, 4'h0);
            nop(T_RC_CYC);
        end
    endtask : init

    task automatic open_rows();
        cmd(CMD_ACT, 2'h0, 13'h0005, 1'b1, 4'h0);
        nop(T_RRD_CYC);
        cmd(CMD_ACT, 2'h1, 13'h0005, 1'b1, 4'h0);
        nop(T_RCD_CYC);
    endtask : open_rows

    // Row must be open the minimum time before it closes
    task automatic close_rows();
        nop(T_RAS_CYC);
        cmd(CMD_PRE, 2'h0, 13'h0400, 1'b1, 4'h0);
        nop(T_RP_CYC);
    endtask : close_rows

    task automatic wr(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] col, input int n,
                      input logic [3:0][DQ_W-1:0] d, input logic [3:0][DQM_W-1:0] m);
        for (int k = 0; k < n; k++) begin
            cmd((k == 0) ? CMD_WR : CMD_NOP, b, col, 1'b1, m[k]);
            wdata <= d[k];
            wdrive <= 1'b1;
        end
        nop(1);
        wdrive <= 1'b0;
    endtask : wr

    // Mask of beat k lands on edge cl + k, where its word leaves for beat 0 always, for later beats only without suspend; suspend holds gate low two edges
    task automatic rd(input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] col, input int n,
                      input int cl, input logic [3:0][DQM_W-1:0] m, input bit susp);
        int last;
        last = cl + n + (susp ? 2 : 0);
        cmd(CMD_RD, b, col, 1'b1, 4'h0);
        for (int e = 1; e < last; e++)
            cmd(CMD_NOP, b, col, !(susp && (e == cl || e == cl + 1)),
                (e >= cl && e - cl < n) ? m[e - cl] : 4'h0);
        nop(1);
    endtask : rd

    // Entry, then an ignored write while the gate stays low
    // Refresh is spread out, not in bursts, so no refresh burst around entry
    task automatic sref_enter();
        cmd(CMD_AREF, 2'h0, 13'h0000, 1'b0, 4'h0);
        cmd(CMD_WR, 2'h0, 13'h0003, 1'b0, 4'h0);
        repeat (T_RAS_CYC) cmd(CMD_NOP, 2'h0, 13'h0000, 1'b0, 4'h0);
    endtask : sref_enter

    task automatic sref_exit();
        repeat (T_SRX_CYC) begin
            @(posedge clk_sys);
            pins <= {1'b1, CMD_NOP, 1'b1, 2'h0, 13'h0000, 4'h0};
        end
        nop(T_RC_CYC);
    endtask : sref_exit
endmodule : sdtc_ctrl_model

// ==== verification/sdtc_core_test.sv ====
// Purpose: Self-checking bench for the device core, queue of expected read words.
// Assumes: Controller model keeps every minimum; memory model mirrors masked writes.
// Notes:   Watcher samples only on edges where the internal gate ran.

`timescale 1ns/1ps

// ============================================================
// Bench top
module sdtc_core_test
    import sdtc_pkg::*;
;
    typedef struct packed {
        logic [DQ_W-1:0] data;
        logic [DQM_W-1:0] oe_n;
    } sdtc_exp_t;
    logic clk_sys;
    logic rstn;
    sdtc_pins_t pins;
    logic [DQ_W-1:0] dq_wire, dq_out, wdata;
    logic [DQ_W-1:0] dq_prev = '0;
    logic [DQM_W-1:0] dq_oe_n;
    logic wdrive, sref_active, en;
    logic ck_q = 1'b1;
    logic [DQ_W-1:0] mem_exp [MEM_WORDS];
    logic [31:0] seed;
    sdtc_exp_t exp_q [$];
    int n_errors, total_checks;
    int cycles = 0;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Released lanes toggle so a stale value never looks valid
    always_comb begin
        for (int i = 0; i < DQM_W; i++)
            dq_wire[i*BYTE_W +: BYTE_W] = wdrive ? wdata[i*BYTE_W +: BYTE_W] :
                !dq_oe_n[i] ? dq_out[i*BYTE_W +: BYTE_W] : ~dq_prev[i*BYTE_W +: BYTE_W];
    end
    always @(posedge clk_sys) dq_prev <= dq_wire;

    sdtc_core u_sdtc_core (.clk_sys(clk_sys), .rstn(rstn), .pins(pins), .dq_in(dq_wire),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .sref_active(sref_active));
    sdtc_ctrl_model u_sdtc_ctrl_model (.clk_sys(clk_sys), .pins(pins), .wdata(wdata),
        .wdrive(wdrive));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [DQ_W-1:0] lanes(input logic [DQM_W-1:0] oe_n);
        for (int i = 0; i < DQM_W; i++) lanes[i*BYTE_W +: BYTE_W] = {BYTE_W{!oe_n[i]}};
    endfunction : lanes

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : close_out

    // Disabled lanes carry no data worth comparing
    task automatic check_word(input sdtc_exp_t e);
        total_checks++;
        if (dq_oe_n !== e.oe_n || ((dq_out ^ e.data) & lanes(e.oe_n)) !== '0) begin
            n_errors++;
            $display("Error at %0t: word %h lanes %h, want %h lanes %h", $time, dq_out,
                dq_oe_n, e.data, e.oe_n);
        end
    endtask : check_word

    task automatic check_flag(input logic v);
        @(negedge clk_sys);
        total_checks++;
        if (sref_active !== v) begin
            n_errors++;
            $display("Error at %0t: self refresh flag %b, want %b", $time, sref_active, v);
        end
    endtask : check_flag

    task automatic drain(input string name);
        int t;
        t = 0;
        while (exp_q.size() != 0 && t < 40) begin
            @(posedge clk_sys);
            t++;
        end
        total_checks++;
        if (exp_q.size() != 0) begin
            n_errors++;
            $display("Error at %0t: read words missing", $time);
        end
        $display("test %s done", name);
    endtask : drain

    // Four-beat write of random words; masked bytes keep old contents
    task automatic bwr(input logic [BA_W-1:0] b, input logic [3:0] col,
                       input logic [3:0][DQM_W-1:0] m);
        logic [3:0][DQ_W-1:0] d;
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            d[k] = seed;
            for (int i = 0; i < DQM_W; i++)
                if (!m[k][i]) mem_exp[{b, col + 4'(k)}][i*BYTE_W +: BYTE_W] = seed[i*BYTE_W +: BYTE_W];
        end
        u_sdtc_ctrl_model.wr(b, {9'h000, col}, 4, d, m);
    endtask : bwr

    task automatic brd(input logic [BA_W-1:0] b, input logic [3:0] col, input int n, input int cl,
                       input logic [3:0][DQM_W-1:0] m, input bit susp);
        for (int k = 0; k < n; k++) exp_q.push_back('{mem_exp[{b, col + 4'(k)}], m[k]});
        u_sdtc_ctrl_model.rd(b, {9'h000, col}, n, cl, m, susp);
    endtask : brd

    // Watcher: skips edges frozen by the gate of the previous edge
    always @(posedge clk_sys) begin
        en = ck_q;
        ck_q <= pins.cke;
        #1;
        if (en === 1'b1 && dq_oe_n !== 4'hf) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("Error at %0t: unexpected read word", $time);
            end else
                check_word(exp_q.pop_front());
        end
    end

    // Hang guard, well past the power-up pause plus all tests
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            n_errors++;
            $display("Error at %0t: run timed out", $time);
            close_out();
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        seed = 32'h87544615;
        n_errors = 0;
        total_checks = 0;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        u_sdtc_ctrl_model.init(13'h0022);
        u_sdtc_ctrl_model.open_rows();
        bwr(2'h0, 4'h0, '0);
        bwr(2'h1, 4'h4, '0);
        bwr(2'h0, 4'h0, {4'h0, 4'h6, 4'hf, 4'h1});
        brd(2'h0, 4'h0, 4, 2, {4'h8, 4'h0, 4'h3, 4'h0}, 1'b0);
        drain("mask");
        brd(2'h1, 4'h4, 4, 2, '0, 1'b1);
        drain("suspend");
        u_sdtc_ctrl_model.close_rows();
        u_sdtc_ctrl_model.cmd(CMD_MRS, 2'h0, 13'h0030, 1'b1, 4'h0);
        u_sdtc_ctrl_model.nop(T_MRS_CYC);
        u_sdtc_ctrl_model.open_rows();
        for (int k = 0; k < 4; k++) begin
            exp_q.push_back('{mem_exp[{2'h0, 4'(k)}], 4'h0});
            u_sdtc_ctrl_model.cmd(CMD_RD, 2'h0, 13'(k), 1'b1, 4'h0);
        end
        u_sdtc_ctrl_model.nop(1);
        drain("back_to_back");
        u_sdtc_ctrl_model.close_rows();
        u_sdtc_ctrl_model.sref_enter();
        check_flag(1'b1);
        u_sdtc_ctrl_model.sref_exit();
        check_flag(1'b0);
        u_sdtc_ctrl_model.cmd(CMD_AREF, 2'h0, 13'h0000, 1'b1, 4'h0);
        u_sdtc_ctrl_model.nop(T_RC_CYC);
        check_flag(1'b0);
        u_sdtc_ctrl_model.open_rows();
        exp_q.push_back('{mem_exp[6'h03], 4'h0});
        u_sdtc_ctrl_model.rd(2'h0, 13'h0003, 1, 3, '0, 1'b0);
        drain("self_refresh");
        close_out();
    end
endmodule : sdtc_core_test
